// ### pkg/strap_pins_pkg.sv
// package for the dual-purpose strap / status pin block
// assumes a single 100 MHz clock and an AXI4-Lite register port with 32-bit data
package strap_pins_pkg;

  // -----------------------------------------------------------------
  // bus geometry
  // -----------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_STRAP_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FEATURE_CFG  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_BATT_CHARGE  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LIVE_STATUS  = 4'hc;

  // decoded register index
  typedef enum logic [2:0] {
    IDX_STRAP  = 3'h0,
    IDX_FEAT   = 3'h1,
    IDX_BATT   = 3'h2,
    IDX_LIVE   = 3'h3,
    IDX_NONE   = 3'h7
  } reg_idx_t;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  // strap status (read only)
  localparam int BIT_STRAP_GANGED     = 0;
  localparam int BIT_STRAP_PWR_SW_DIS = 1;
  localparam int BIT_STRAP_SERIAL     = 2;
  localparam int BIT_STRAP_AUTO_DIS   = 3;
  localparam int BIT_STRAP_VALID      = 4;
  // feature configuration (read / write)
  localparam int BIT_FEAT_HS_UPSTREAM_CONNECTED_OUT   = 0;
  localparam int BIT_FEAT_HS_SUSP_OUT = 1;
  // battery charging support (read / write)
  localparam int BIT_BATT_AUTO_DIS    = 0;
  // live status (read only)
  localparam int BIT_LIVE_HS_CONN     = 0;
  localparam int BIT_LIVE_HS_SUSP     = 1;
  localparam int BIT_LIVE_AUTO_ACT    = 2;
  localparam int BIT_LIVE_CDP1        = 3;
  localparam int BIT_LIVE_ADDR1       = 4;
  localparam int BIT_LIVE_ADDR2       = 5;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic RST_FEAT_HS_UPSTREAM_CONNECTED_OUT   = 1'b0;
  localparam logic RST_FEAT_HS_SUSP_OUT = 1'b0;
  localparam logic RST_BATT_AUTO_DIS    = 1'b1;

  // -----------------------------------------------------------------
  // strap vector layout
  // -----------------------------------------------------------------
  localparam int STRAP_N       = 4;
  localparam int STRAP_GANG    = 0;
  localparam int STRAP_PWR_DIS = 1;
  localparam int STRAP_SERIAL  = 2;
  localparam int STRAP_AUTO    = 3;

endpackage : strap_pins_pkg

// ### hdl/strap_capture.sv
// one-shot capture of strap pin levels
// assumes the pins are synchronous to CLK and stay undriven by the block until done is high
`timescale 1ns/1ps

module strap_capture
  import strap_pins_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire logic [STRAP_N-1:0] PINS,
  output logic      [STRAP_N-1:0] VALUE,
  output logic                    DONE
);

  typedef struct packed {
    logic [STRAP_N-1:0] value;
    logic               done;
  } cap_state_t;

  cap_state_t cap_r;
  cap_state_t cap_nxt;

  // -----------------------------------------------------------------
  // capture on the first edge after reset release, then freeze
  // -----------------------------------------------------------------
  always_comb begin
    cap_nxt = cap_r;
    if (!cap_r.done) begin
      cap_nxt.value = PINS; // R1 R5 R9 R10
      cap_nxt.done  = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  assign VALUE = cap_r.value;
  assign DONE  = cap_r.done;

endmodule : strap_capture

// ### hdl/strap_sample_status_pins.sv
// strap sampling and status output logic for two dual-purpose hub pins, with an AXI4-Lite register port
// assumes all inputs synchronous to CLK; the bench resolves pin levels from the active-low enables
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// How it works
// R1: at reset release, gang pin low means per-port, high means ganged, if switching on.
// R2: in SMBus mode the gang pin level becomes slave address bit 2.
// R3: when enabled after reset, gang pin shows high-speed upstream connection.
// R4: board must strap individual power control when battery charging is used.
// R5: at reset release, auto pin low enables automatic charge, high disables it.
// R6: while automatic charge mode is on, port 1 offers no CDP behaviour.
// R7: captured auto pin level seeds the automatic-mode-disable bit.
// R8: when enabled after reset, auto pin shows high-speed upstream suspend.
// R9: serial mode strap high selects I2C master, low selects SMBus slave.
// R10: power switching strap low enables switching, high disables it and gang choice.
// R11: in SMBus mode the power switching strap level becomes slave address bit 1.
// R12: pins stay inputs until straps are captured; drivers turn on only afterwards.
module strap_sample_status_pins
  import strap_pins_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [DATA_W-1:0]      RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // dual-purpose pins
  input  wire logic              GANG_PIN_IN,
  output logic                   GANG_PIN_OUT,
  output logic                   GANG_PIN_OE_N,
  input  wire logic              AUTO_PIN_IN,
  output logic                   AUTO_PIN_OUT,
  output logic                   AUTO_PIN_OE_N,
  // other straps
  input  wire logic              SERIAL_PORT_MODE_STRAP,
  input  wire logic              POWER_SWITCHING_DISABLE_STRAP,
  // hub core status
  input  wire logic              HS_UPSTREAM_CONNECTED,
  input  wire logic              HS_UPSTREAM_SUSPENDED,
  input  wire logic              HUB_CONNECTED,
  // hub core controls
  output logic                   STRAPS_VALID,
  output logic                   PORT_POWER_SWITCH_EN,
  output logic                   PORT_POWER_GANGED,
  output logic                   SMBUS_MODE,
  output logic                   SMBUS_ADDR_BIT1_STRAP,
  output logic                   SMBUS_ADDR_BIT2_STRAP,
  output logic                   AUTO_CHARGE_ACTIVE,
  output logic                   PORT1_CDP_ALLOW
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    // write channel
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] waddr;
    logic [7:0]        wbyte;
    logic              wlane0;
    logic              bvalid;
    logic [1:0]        bresp;
    // read channel
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    // configuration
    logic              hs_upstream_connected_out_en;
    logic              hs_susp_out_en;
    logic              auto_charge_disable_bit;
    logic              seeded;
    // pins
    logic              gang_out;
    logic              gang_oe_n;
    logic              auto_out;
    logic              auto_oe_n;
    // core controls
    logic              valid;
    logic              pwr_sw_en;
    logic              ganged;
    logic              smbus_mode;
    logic              addr_bit1;
    logic              addr_bit2;
    logic              auto_active;
    logic              cdp1_allow;
  } top_state_t;

  localparam top_state_t TOP_RST = '{
    gang_oe_n               : 1'b1,
    auto_oe_n               : 1'b1,
    hs_upstream_connected_out_en            : RST_FEAT_HS_UPSTREAM_CONNECTED_OUT,
    hs_susp_out_en          : RST_FEAT_HS_SUSP_OUT,
    auto_charge_disable_bit : RST_BATT_AUTO_DIS,
    default                 : '0
  };

  top_state_t st_r;
  top_state_t st_nxt;

  logic [STRAP_N-1:0] strap_val;
  logic               strap_done;

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  strap_capture u_capture (
    .CLK   (CLK),
    .RSTN  (RSTN),
    .PINS  ({AUTO_PIN_IN, SERIAL_PORT_MODE_STRAP, POWER_SWITCHING_DISABLE_STRAP, GANG_PIN_IN}),
    .VALUE (strap_val),
    .DONE  (strap_done)
  );

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  function automatic reg_idx_t decode(input logic [ADDR_W-1:0] addr);
    reg_idx_t idx;
    case (addr)
      OFS_STRAP_STATUS: idx = IDX_STRAP;
      OFS_FEATURE_CFG:  idx = IDX_FEAT;
      OFS_BATT_CHARGE:  idx = IDX_BATT;
      OFS_LIVE_STATUS:  idx = IDX_LIVE;
      default:          idx = IDX_NONE;
    endcase
    return idx;
  endfunction : decode

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // write address and data, taken in either order
    if (AWVALID && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.waddr   = AWADDR;
    end
    if (WVALID && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wbyte  = WDATA[7:0];
      st_nxt.wlane0 = WSTRB[0];
    end
    if (st_r.bvalid && BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      case (decode(st_r.waddr))
        IDX_FEAT: begin
          if (st_r.wlane0) begin
            st_nxt.hs_upstream_connected_out_en   = st_r.wbyte[BIT_FEAT_HS_UPSTREAM_CONNECTED_OUT];
            st_nxt.hs_susp_out_en = st_r.wbyte[BIT_FEAT_HS_SUSP_OUT];
          end
        end
        IDX_BATT: begin
          if (st_r.wlane0) begin
            st_nxt.auto_charge_disable_bit = st_r.wbyte[BIT_BATT_AUTO_DIS];
          end
        end
        IDX_STRAP, IDX_LIVE: begin
          st_nxt.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

    // read channel
    if (st_r.rvalid && RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ARVALID && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = '0;
      case (decode(ARADDR))
        IDX_STRAP: begin
          st_nxt.rdata[BIT_STRAP_GANGED]     = strap_val[STRAP_GANG];
          st_nxt.rdata[BIT_STRAP_PWR_SW_DIS] = strap_val[STRAP_PWR_DIS];
          st_nxt.rdata[BIT_STRAP_SERIAL]     = strap_val[STRAP_SERIAL];
          st_nxt.rdata[BIT_STRAP_AUTO_DIS]   = strap_val[STRAP_AUTO];
          st_nxt.rdata[BIT_STRAP_VALID]      = st_r.valid;
        end
        IDX_FEAT: begin
          st_nxt.rdata[BIT_FEAT_HS_UPSTREAM_CONNECTED_OUT]   = st_r.hs_upstream_connected_out_en;
          st_nxt.rdata[BIT_FEAT_HS_SUSP_OUT] = st_r.hs_susp_out_en;
        end
        IDX_BATT: begin
          st_nxt.rdata[BIT_BATT_AUTO_DIS] = st_r.auto_charge_disable_bit;
        end
        IDX_LIVE: begin
          st_nxt.rdata[BIT_LIVE_HS_CONN]  = HS_UPSTREAM_CONNECTED;
          st_nxt.rdata[BIT_LIVE_HS_SUSP]  = HS_UPSTREAM_SUSPENDED;
          st_nxt.rdata[BIT_LIVE_AUTO_ACT] = st_r.auto_active;
          st_nxt.rdata[BIT_LIVE_CDP1]     = st_r.cdp1_allow;
          st_nxt.rdata[BIT_LIVE_ADDR1]    = st_r.addr_bit1;
          st_nxt.rdata[BIT_LIVE_ADDR2]    = st_r.addr_bit2;
        end
        default: begin
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // seed the battery charging bit once, from the captured level
    if (strap_done && !st_r.seeded) begin
      st_nxt.auto_charge_disable_bit = strap_val[STRAP_AUTO]; // R7
      st_nxt.seeded                  = 1'b1;
    end

    // strap-derived controls, held low until the straps are known
    st_nxt.valid      = strap_done;
    st_nxt.pwr_sw_en  = strap_done && !strap_val[STRAP_PWR_DIS]; // R10
    // gang choice only counts while switching is enabled
    st_nxt.ganged     = strap_done && !strap_val[STRAP_PWR_DIS] && strap_val[STRAP_GANG]; // R1 R10
    st_nxt.smbus_mode = strap_done && !strap_val[STRAP_SERIAL]; // R9
    st_nxt.addr_bit1  = strap_done && !strap_val[STRAP_SERIAL] && strap_val[STRAP_PWR_DIS]; // R11
    st_nxt.addr_bit2  = strap_done && !strap_val[STRAP_SERIAL] && strap_val[STRAP_GANG]; // R2

    // automatic charge mode
    st_nxt.auto_active = st_r.seeded && !st_r.auto_charge_disable_bit && !HUB_CONNECTED; // R5
    st_nxt.cdp1_allow  = st_r.seeded && st_r.auto_charge_disable_bit; // R6

    // status outputs on the dual-purpose pins
    st_nxt.gang_out  = HS_UPSTREAM_CONNECTED; // R3
    st_nxt.gang_oe_n = !(strap_done && st_r.hs_upstream_connected_out_en); // R12
    st_nxt.auto_out  = HS_UPSTREAM_SUSPENDED; // R8
    st_nxt.auto_oe_n = !(strap_done && st_r.hs_susp_out_en); // R12
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign AWREADY               = st_r.awready;
  assign WREADY                = st_r.wready;
  assign BVALID                = st_r.bvalid;
  assign BRESP                 = st_r.bresp;
  assign ARREADY               = st_r.arready;
  assign RVALID                = st_r.rvalid;
  assign RRESP                 = st_r.rresp;
  assign RDATA                 = st_r.rdata;
  assign GANG_PIN_OUT          = st_r.gang_out;
  assign GANG_PIN_OE_N         = st_r.gang_oe_n;
  assign AUTO_PIN_OUT          = st_r.auto_out;
  assign AUTO_PIN_OE_N         = st_r.auto_oe_n;
  assign STRAPS_VALID          = st_r.valid;
  assign PORT_POWER_SWITCH_EN  = st_r.pwr_sw_en;
  assign PORT_POWER_GANGED     = st_r.ganged;
  assign SMBUS_MODE            = st_r.smbus_mode;
  assign SMBUS_ADDR_BIT1_STRAP = st_r.addr_bit1;
  assign SMBUS_ADDR_BIT2_STRAP = st_r.addr_bit2;
  assign AUTO_CHARGE_ACTIVE    = st_r.auto_active;
  assign PORT1_CDP_ALLOW       = st_r.cdp1_allow;

endmodule : strap_sample_status_pins

// ### bench/strap_board_model.sv
// board side of the two dual-purpose pins: strap resistors and status sensing
// assumes the bench sets the strap levels while the block is held in reset
`timescale 1ns/1ps

module strap_board_model
  import strap_pins_pkg::*;
#(
  parameter bit BATT_CHARGING = 1'b0
)
(
  input  wire logic [STRAP_N-1:0] straps,
  input  wire logic               gang_out,
  input  wire logic               gang_oe_n,
  input  wire logic               auto_out,
  input  wire logic               auto_oe_n,
  output logic                    gang_in,
  output logic                    auto_in,
  output logic                    serial_mode,
  output logic                    pwr_dis
);
  // -----------------------------------------------------------------
  // wire resolution
  // -----------------------------------------------------------------
  // a released pin shows its strap resistor level
  // a charging board never straps ganged control
  assign gang_in     = gang_oe_n ? (straps[STRAP_GANG] & ~BATT_CHARGING) : gang_out;
  assign auto_in     = auto_oe_n ? straps[STRAP_AUTO] : auto_out;
  assign serial_mode = straps[STRAP_SERIAL];
  assign pwr_dis     = straps[STRAP_PWR_DIS];
endmodule : strap_board_model

// ### bench/strap_sample_status_pins_props.sv
// concurrent checks on the strap and status pin block
// assumes it is bound into the block and sees only its ports
`timescale 1ns/1ps

module strap_pins_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic GANG_PIN_IN,
  input wire logic GANG_PIN_OUT,
  input wire logic GANG_PIN_OE_N,
  input wire logic AUTO_PIN_IN,
  input wire logic AUTO_PIN_OUT,
  input wire logic AUTO_PIN_OE_N,
  input wire logic SERIAL_PORT_MODE_STRAP,
  input wire logic POWER_SWITCHING_DISABLE_STRAP,
  input wire logic HS_UPSTREAM_CONNECTED,
  input wire logic HS_UPSTREAM_SUSPENDED,
  input wire logic HUB_CONNECTED,
  input wire logic STRAPS_VALID,
  input wire logic PORT_POWER_SWITCH_EN,
  input wire logic PORT_POWER_GANGED,
  input wire logic SMBUS_MODE,
  input wire logic SMBUS_ADDR_BIT1_STRAP,
  input wire logic SMBUS_ADDR_BIT2_STRAP,
  input wire logic AUTO_CHARGE_ACTIVE,
  input wire logic PORT1_CDP_ALLOW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  sequence capture_s;
    $rose(STRAPS_VALID);
  endsequence

  pins_input_a: assert property (!STRAPS_VALID |-> GANG_PIN_OE_N && AUTO_PIN_OE_N)
    else $error("pin driven before capture");
  gang_mode_a: assert property (capture_s |-> PORT_POWER_GANGED ==
    ($past(GANG_PIN_IN) && !$past(POWER_SWITCHING_DISABLE_STRAP))) else $error("gang mode wrong");
  addr_bit2_a: assert property (capture_s |-> SMBUS_ADDR_BIT2_STRAP ==
    (!$past(SERIAL_PORT_MODE_STRAP) && $past(GANG_PIN_IN))) else $error("address bit 2 wrong");
  addr_bit1_a: assert property (capture_s |-> SMBUS_ADDR_BIT1_STRAP ==
    (!$past(SERIAL_PORT_MODE_STRAP) && $past(POWER_SWITCHING_DISABLE_STRAP))) else $error("address bit 1 wrong");
  switch_mode_a: assert property (capture_s |-> PORT_POWER_SWITCH_EN != $past(POWER_SWITCHING_DISABLE_STRAP))
    else $error("switch enable wrong");
  serial_mode_a: assert property (capture_s |-> SMBUS_MODE != $past(SERIAL_PORT_MODE_STRAP))
    else $error("serial mode wrong");
  auto_seed_a: assert property (capture_s |=> PORT1_CDP_ALLOW == $past(AUTO_PIN_IN, 2))
    else $error("auto bit not seeded");
  cdp_block_a: assert property (AUTO_CHARGE_ACTIVE |-> !PORT1_CDP_ALLOW && !$past(HUB_CONNECTED))
    else $error("auto mode conflict");

  // -----------------------------------------------------------------
  // status outputs
  // -----------------------------------------------------------------
  hs_conn_a: assert property (!GANG_PIN_OE_N |-> GANG_PIN_OUT == $past(HS_UPSTREAM_CONNECTED))
    else $error("connect status wrong");
  hs_susp_a: assert property (!AUTO_PIN_OE_N |-> AUTO_PIN_OUT == $past(HS_UPSTREAM_SUSPENDED))
    else $error("suspend status wrong");
endmodule : strap_pins_props

bind strap_sample_status_pins strap_pins_props i_props (.*);

// ### bench/strap_sample_status_pins_test.sv
// self-checking bench for the strap and status pin block
// assumes the board model resolves both dual-purpose pins
`timescale 1ns/1ps

module strap_sample_status_pins_test
  import strap_pins_pkg::*;
;
  logic              CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic              RVALID, RREADY, GANG_PIN_IN, GANG_PIN_OUT, GANG_PIN_OE_N, AUTO_PIN_IN, AUTO_PIN_OUT;
  logic              AUTO_PIN_OE_N, SERIAL_PORT_MODE_STRAP, POWER_SWITCHING_DISABLE_STRAP, HUB_CONNECTED;
  logic              HS_UPSTREAM_CONNECTED, HS_UPSTREAM_SUSPENDED, STRAPS_VALID, PORT_POWER_SWITCH_EN;
  logic              PORT_POWER_GANGED, SMBUS_MODE, SMBUS_ADDR_BIT1_STRAP, SMBUS_ADDR_BIT2_STRAP;
  logic              AUTO_CHARGE_ACTIVE, PORT1_CDP_ALLOW;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [DATA_W-1:0] WDATA, RDATA, rd_data;
  logic [3:0]        WSTRB, straps;
  logic [1:0]        BRESP, RRESP, resp;
  int                n_errors = 0;
  int                n_checks = 0;

  strap_sample_status_pins i_dut (.*);
  strap_board_model i_board (.straps(straps), .gang_out(GANG_PIN_OUT), .gang_oe_n(GANG_PIN_OE_N),
    .auto_out(AUTO_PIN_OUT), .auto_oe_n(AUTO_PIN_OE_N), .gang_in(GANG_PIN_IN), .auto_in(AUTO_PIN_IN),
    .serial_mode(SERIAL_PORT_MODE_STRAP), .pwr_dis(POWER_SWITCHING_DISABLE_STRAP));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task rst(input logic [3:0] s, input logic hub);
    @(posedge CLK);
    RSTN <= 1'b0;
    straps <= s;
    HUB_CONNECTED <= hub;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
  endtask : rst

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    fork
      begin
        @(posedge CLK iff AWREADY);
        AWVALID <= 1'b0;
      end
      begin
        @(posedge CLK iff WREADY);
        WVALID <= 1'b0;
      end
    join
    @(posedge CLK iff BVALID);
    resp = BRESP;
    BREADY <= 1'b0;
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    @(posedge CLK iff ARREADY);
    ARVALID <= 1'b0;
    @(posedge CLK iff RVALID);
    rd_data = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask : rd

  task settle;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
  endtask : settle

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    #50000;
    n_errors++;
    conclude();
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    RSTN = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, HS_UPSTREAM_CONNECTED, HS_UPSTREAM_SUSPENDED} = '0;
    {AWADDR, ARADDR, WDATA, straps, HUB_CONNECTED} = '0;
    WSTRB = 4'h1;
    // every strap combination, hub connection following the serial strap
    for (int i = 0; i < 16; i++) begin
      rst(i[3:0], i[2]);
      chk({22'h0, STRAPS_VALID, PORT_POWER_SWITCH_EN, PORT_POWER_GANGED, SMBUS_MODE, SMBUS_ADDR_BIT1_STRAP,
        SMBUS_ADDR_BIT2_STRAP, PORT1_CDP_ALLOW, AUTO_CHARGE_ACTIVE, GANG_PIN_OE_N, AUTO_PIN_OE_N},
        {22'h0, 1'b1, !i[1], i[0] & !i[1], !i[2], !i[2] & i[1], !i[2] & i[0], i[3], !i[3] & !i[2], 2'b11},
        "strap controls");
      rd(OFS_STRAP_STATUS);
      chk(rd_data, {27'h0, 1'b1, i[3:0]}, "strap status");
      rd(OFS_BATT_CHARGE);
      chk(rd_data, {31'h0, i[3]}, "charge bit");
    end
    $display("test straps done");
    // status on the pins, strapped high so driven lows show
    rst(4'h9, 1'b1);
    wr(OFS_FEATURE_CFG, 32'h3);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "feature write");
    for (int j = 0; j < 4; j++) begin
      @(posedge CLK);
      HS_UPSTREAM_CONNECTED <= j[0];
      HS_UPSTREAM_SUSPENDED <= j[1];
      settle();
      chk({28'h0, GANG_PIN_OE_N, AUTO_PIN_OE_N, AUTO_PIN_IN, GANG_PIN_IN}, {30'h0, j[1:0]}, "pins");
      rd(OFS_LIVE_STATUS);
      // ganged strap in smbus mode, auto strap high, hub connected: addr2 and cdp1 set, addr1 and auto clear
      chk(rd_data, {26'h0, 4'ha, j[1:0]}, "live status");
    end
    wr(OFS_FEATURE_CFG, 32'h0);
    settle();
    chk({28'h0, GANG_PIN_OE_N, AUTO_PIN_OE_N, AUTO_PIN_IN, GANG_PIN_IN}, 32'hf, "pins released");
    $display("test pins done");
    // software rewrites the seeded bit; read-only and unmapped places
    wr(OFS_BATT_CHARGE, 32'h0);
    rd(OFS_BATT_CHARGE);
    chk(rd_data, 32'h0, "charge bit write");
    @(posedge CLK);
    HUB_CONNECTED <= 1'b0;
    settle();
    chk({30'h0, AUTO_CHARGE_ACTIVE, PORT1_CDP_ALLOW}, 32'h2, "auto mode");
    wr(OFS_STRAP_STATUS, 32'h0);
    rd(OFS_STRAP_STATUS);
    chk(rd_data, 32'h19, "strap status kept");
    rd(4'h2);
    chk({rd_data[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(4'h2, 32'hff);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("test registers done");
    conclude();
  end
endmodule : strap_sample_status_pins_test
